// ### pkg/vmb_defs.svh
// Field positions, reset values, clock rate, timeout periods and codes of the broadcast bridge
`ifndef VMB_DEFS_SVH
`define VMB_DEFS_SVH

// Clock rate in MHz, used to turn times into cycles
`define VMB_CLK_MHZ 100
// Transaction timeout periods in microseconds
`define VMB_TO1_US 32
`define VMB_TO2_US 128
`define VMB_TO3_US 512
// Timeout select codes
`define VMB_TO_CODE1 2'h1
`define VMB_TO_CODE2 2'h2
`define VMB_TO_CODE3 2'h3
// Broadcast address fields within the 32-bit VMEbus address
`define VMB_PAGE_MSB 31
`define VMB_PAGE_LSB 24
`define VMB_CHAN_BIT 23
`define VMB_SLOTS_MSB 20
`define VMB_SLOTS_LSB 0
// Number of participating hosts and channels
`define VMB_NUM_SLOTS 21
`define VMB_NUM_CHAN 2
// Highest programmable slot number
`define VMB_SLOT_MAX 5'h15
// Address modifier for the A32 non-privileged data window
`define VMB_AM_A32 6'h09
// Reset values
`define VMB_RST_SLOT 5'h00
`define VMB_RST_PAGE 8'h00
`define VMB_RST_MAP 3'h0
// Message FIFO depth per channel
`define VMB_FIFO_DEPTH 4

`endif

// ### pkg/vmb_pkg.sv
// Types shared by the broadcast bridge modules
package vmb_pkg;

  // Interrupt routing: request line number and enable
  typedef struct packed {
    logic [2:0] map;
    logic en;
  } vmb_irq_sel_t;

  // Fail and abort interrupt settings, frozen once locked
  typedef struct packed {
    vmb_irq_sel_t sysfail;
    vmb_irq_sel_t acfail;
    vmb_irq_sel_t abort_sw;
  } vmb_fail_cfg_t;

  // Broadcast cycle address layout
  typedef struct packed {
    logic [7:0] page;
    logic chan;
    logic [1:0] rsvd;
    logic [20:0] slots;
  } vmb_bcast_addr_t;

  // Captured error record
  typedef struct packed {
    logic pending;
    logic [31:0] addr;
  } vmb_err_t;

endpackage : vmb_pkg

// ### src/vmb_fifo.sv
// Small message FIFO with registered head read
`timescale 1ns/1ps
`default_nettype none

module vmb_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic [W-1:0] out_data_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // Full and empty come straight from the occupancy count
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = out_data_r;

  // Pointer wrap; depth need not be a power of two
  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    inc_ptr = (p == AW'(D - 1)) ? '0 : p + AW'(1);
  endfunction : inc_ptr

  // Storage is not reset, only the pointers, count and head register
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // Head word is registered on pop, valid the cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      out_data_r <= '0;
    end else if (ce) begin
      if (push) wr_ptr_r <= inc_ptr(wr_ptr_r);
      if (pop) begin
        rd_ptr_r <= inc_ptr(rd_ptr_r);
        out_data_r <= mem[rd_ptr_r];
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : vmb_fifo

`default_nettype wire

// ### src/vmb_bridge.sv
// Broadcast message channels, error capture, freeze, DTB control and transaction timer
`timescale 1ns/1ps
`default_nettype none
`include "vmb_defs.svh"

module vmb_bridge
  import vmb_pkg::*;
#(
  parameter int TO1_CYC = `VMB_TO1_US * `VMB_CLK_MHZ,
  parameter int TO2_CYC = `VMB_TO2_US * `VMB_CLK_MHZ,
  parameter int TO3_CYC = `VMB_TO3_US * `VMB_CLK_MHZ,
  parameter int DEPTH = `VMB_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Configuration
  input wire logic [1:0] chan_en,
  input wire logic [4:0] slot_num,
  input wire logic [7:0] page,
  input wire logic user_access_ok,
  // Incoming broadcast writes from the VMEbus slave side
  input wire logic bc_valid,
  input wire logic [31:0] bc_addr,
  input wire logic [31:0] bc_data,
  output logic bc_accepted,
  output logic bc_rejected,
  // Channel status
  output logic [1:0] msg_available,
  output logic [1:0] accepted_pending,
  output logic [1:0] rejected_message_pending,
  input wire logic [1:0] clear_accepted_pending,
  input wire logic [1:0] clear_rejected_pending,
  // Message read port
  input wire logic rd_req,
  input wire logic rd_chan,
  input wire logic rd_priv,
  output logic rd_done,
  output logic rd_avail,
  output logic rd_denied,
  output logic [31:0] rd_data,
  // Message send port
  input wire logic send_req,
  input wire logic send_chan,
  input wire logic [31:0] send_msg,
  input wire logic [31:0] send_slots,
  output logic send_busy,
  output logic send_done,
  output logic send_ok,
  output logic send_berr,
  // VMEbus master window
  output logic m_req,
  output logic [31:0] m_addr,
  output logic [31:0] m_data,
  output logic [5:0] m_am,
  output logic m_posted,
  input wire logic m_ack,
  input wire logic m_rejected,
  output logic m_abort,
  // Transaction timer
  input wire logic timer_en,
  input wire logic [1:0] timeout_code,
  // Posting and late errors
  input wire logic vme_wperr_evt,
  input wire logic [31:0] vme_wperr_addr,
  input wire logic sbus_wperr_evt,
  input wire logic [31:0] sbus_wperr_addr,
  input wire logic wperr_clear_vme,
  input wire logic wperr_clear_sbus,
  input wire logic late_err_evt,
  input wire logic [31:0] late_err_addr_in,
  input wire logic late_err_clear,
  input wire vmb_irq_sel_t wperr_irq_cfg,
  input wire vmb_irq_sel_t late_irq_cfg,
  output logic vme_posted_write_error_pending,
  output logic sbus_posted_write_error_pending,
  output logic late_error_pending,
  output logic [31:0] vme_wperr_addr_q,
  output logic [31:0] sbus_wperr_addr_q,
  output logic [31:0] late_err_addr_q,
  output logic [7:0] irq_lines,
  // Fail and abort interrupt settings with freeze
  input wire logic fail_cfg_wr,
  input wire vmb_fail_cfg_t fail_cfg_in,
  input wire logic freeze_set,
  output vmb_fail_cfg_t fail_cfg,
  output logic frozen,
  // Data transfer bus drivers
  input wire logic dtb_drv_en,
  output logic dtb_drivers_on
);

  typedef enum logic [1:0] {S_IDLE, S_BUS, S_LOOP, S_DONE} vmb_snd_st_t;

  // Mask bit n selects slot n+1; slot 0 is never addressed
  function automatic logic slot_hit(input logic [4:0] slot, input logic [31:0] mask);
    logic [20:0] m;
    m = mask[`VMB_SLOTS_MSB:`VMB_SLOTS_LSB];
    slot_hit = (slot != 5'h00) && (slot <= `VMB_SLOT_MAX) && m[slot - 5'h01];
  endfunction : slot_hit

  // One-hot request line from a 3-bit route when enabled
  function automatic logic [7:0] route_irq(input vmb_irq_sel_t sel, input logic pend);
    route_irq = (sel.en && pend) ? (8'h01 << sel.map) : 8'h00;
  endfunction : route_irq

  vmb_snd_st_t st_r, st_nxt;
  vmb_bcast_addr_t bc_a;
  logic [31:0] msg_r;
  logic [31:0] slots_r;
  logic chan_r;
  logic fail_r;
  logic berr_r;
  logic [15:0] tmr_r;
  logic [1:0] acc_r, rej_r;
  logic [1:0] f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [31:0] f_in_data [2];
  logic [31:0] f_out_data [2];
  logic rd_stage_r, rd_ans_r, rd_had_r, rd_den_r, rd_ch_r;
  logic [31:0] rd_data_r;
  vmb_err_t vme_err_r, sbus_err_r, late_err_r;
  vmb_fail_cfg_t fail_cfg_r;
  logic frozen_r;
  logic dtb_r;

  // Incoming broadcast decode: page match, then our slot in the mask
  assign bc_a = bc_addr;
  wire bc_hit = bc_valid && (bc_a.page == page) && slot_hit(slot_num, bc_addr);
  wire loop_push = (st_r == S_LOOP);
  // The bus cycle wins the channel; the looped copy waits while bus hits on that channel continue
  wire loop_go = loop_push && !(bc_hit && (bc_a.chan == chan_r));
  wire loop_ok = chan_en[chan_r] && f_in_ready[chan_r];

  // Read access check: user mode only when allowed
  wire rd_allow = rd_priv || user_access_ok;
  // A request during either read stage is dropped, so it must not pop either
  wire rd_take = rd_req && !rd_stage_r && !rd_ans_r;

  // Per-channel push, accept and reject, generated for both channels
  logic [1:0] bc_acc_ch, bc_rej_ch, lp_acc_ch, lp_rej_ch;
  genvar g;
  generate
    for (g = 0; g < `VMB_NUM_CHAN; g++) begin : g_chan
      wire bc_sel = bc_hit && (bc_a.chan == 1'(g));
      wire lp_sel = loop_go && (chan_r == 1'(g));
      // Disabled or full channel rejects; the full FIFO is the back-pressure
      assign bc_acc_ch[g] = bc_sel && chan_en[g] && f_in_ready[g];
      assign bc_rej_ch[g] = bc_sel && !(chan_en[g] && f_in_ready[g]);
      assign lp_acc_ch[g] = lp_sel && loop_ok;
      assign lp_rej_ch[g] = lp_sel && !loop_ok;
      assign f_in_valid[g] = bc_acc_ch[g] || lp_acc_ch[g];
      assign f_in_data[g] = bc_sel ? bc_data : msg_r;
      assign f_out_ready[g] = ce && rd_take && (rd_chan == 1'(g)) && rd_allow;

      vmb_fifo #(
        .W(32),
        .D(DEPTH)
      ) u_fifo (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .in_valid(f_in_valid[g]),
        .in_ready(f_in_ready[g]),
        .in_data(f_in_data[g]),
        .out_valid(f_out_valid[g]),
        .out_ready(f_out_ready[g]),
        .out_data(f_out_data[g])
      );

      // Sticky flags; a new event beats a clear in the same cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          acc_r[g] <= 1'b0;
          rej_r[g] <= 1'b0;
        end else if (ce) begin
          acc_r[g] <= (bc_acc_ch[g] || lp_acc_ch[g]) || (acc_r[g] && !clear_accepted_pending[g]);
          rej_r[g] <= (bc_rej_ch[g] || lp_rej_ch[g]) || (rej_r[g] && !clear_rejected_pending[g]);
        end
      end
    end
  endgenerate

  assign bc_accepted = |bc_acc_ch;
  assign bc_rejected = |bc_rej_ch;
  assign msg_available = f_out_valid;
  assign accepted_pending = acc_r;
  assign rejected_message_pending = rej_r;

  // Read takes two cycles: pop, then capture the registered head word
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_stage_r <= 1'b0;
      rd_ans_r <= 1'b0;
      rd_had_r <= 1'b0;
      rd_den_r <= 1'b0;
      rd_ch_r <= 1'b0;
      rd_data_r <= '0;
    end else if (ce) begin
      rd_stage_r <= rd_take;
      rd_ans_r <= rd_stage_r;
      if (rd_take) begin
        rd_ch_r <= rd_chan;
        rd_den_r <= !rd_allow;
        rd_had_r <= rd_allow && f_out_valid[rd_chan];
      end
      if (rd_stage_r) begin
        rd_data_r <= rd_had_r ? f_out_data[rd_ch_r] : 32'h0000_0000;
      end
    end
  end

  assign rd_done = rd_ans_r;
  assign rd_avail = rd_ans_r && rd_had_r;
  assign rd_denied = rd_ans_r && rd_den_r;
  assign rd_data = rd_data_r;

  // Timeout period; codes outside 1..3 fall to the longest
  wire [15:0] to_lim = (timeout_code == `VMB_TO_CODE1) ? 16'(TO1_CYC) :
                       (timeout_code == `VMB_TO_CODE2) ? 16'(TO2_CYC) : 16'(TO3_CYC);
  wire tmr_exp = timer_en && (tmr_r >= to_lim - 16'h0001);
  wire self_hit = slot_hit(slot_num, slots_r);

  // Sender sequence: bus write, optional loopback, then done
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_IDLE: if (send_req) st_nxt = S_BUS;
      S_BUS: begin
        if (m_ack) st_nxt = self_hit ? S_LOOP : S_DONE;
        else if (tmr_exp) st_nxt = S_DONE;
      end
      S_LOOP: if (loop_go) st_nxt = S_DONE;
      S_DONE: st_nxt = S_IDLE;
    endcase
  end

  // Send request latch, timer and outcome
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= S_IDLE;
      msg_r <= '0;
      slots_r <= '0;
      chan_r <= 1'b0;
      fail_r <= 1'b0;
      berr_r <= 1'b0;
      tmr_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
      tmr_r <= (st_r == S_BUS && timer_en) ? tmr_r + 16'h0001 : 16'h0000;
      if (st_r == S_IDLE && send_req) begin
        msg_r <= send_msg;
        slots_r <= {11'h000, send_slots[`VMB_SLOTS_MSB:`VMB_SLOTS_LSB]};
        chan_r <= send_chan;
        fail_r <= 1'b0;
        berr_r <= 1'b0;
      end
      if (st_r == S_BUS && m_ack && m_rejected) fail_r <= 1'b1;
      if (st_r == S_BUS && !m_ack && tmr_exp) berr_r <= 1'b1;
      if (loop_go && !loop_ok) fail_r <= 1'b1;
    end
  end

  // Master window: page, channel and slot mask form the A32 address
  assign m_req = (st_r == S_BUS);
  assign m_addr = {page, chan_r, 2'b00, slots_r[20:0]};
  assign m_data = msg_r;
  assign m_am = `VMB_AM_A32;
  assign m_posted = 1'b0;
  assign m_abort = (st_r == S_BUS) && !m_ack && tmr_exp;
  assign send_busy = (st_r != S_IDLE);
  assign send_done = (st_r == S_DONE);
  assign send_ok = (st_r == S_DONE) && !fail_r && !berr_r;
  assign send_berr = (st_r == S_DONE) && berr_r;

  // Error capture: each event overwrites the address; the flag holds until software clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      vme_err_r <= '0;
      sbus_err_r <= '0;
      late_err_r <= '0;
    end else if (ce) begin
      if (vme_wperr_evt) vme_err_r <= '{pending: 1'b1, addr: vme_wperr_addr};
      else if (wperr_clear_vme) vme_err_r.pending <= 1'b0;
      if (sbus_wperr_evt) sbus_err_r <= '{pending: 1'b1, addr: sbus_wperr_addr};
      else if (wperr_clear_sbus) sbus_err_r.pending <= 1'b0;
      if (late_err_evt) late_err_r <= '{pending: 1'b1, addr: late_err_addr_in};
      else if (late_err_clear) late_err_r.pending <= 1'b0;
    end
  end

  assign vme_posted_write_error_pending = vme_err_r.pending;
  assign sbus_posted_write_error_pending = sbus_err_r.pending;
  assign late_error_pending = late_err_r.pending;
  assign vme_wperr_addr_q = vme_err_r.addr;
  assign sbus_wperr_addr_q = sbus_err_r.addr;
  assign late_err_addr_q = late_err_r.addr;

  // Both posting errors share one route; late error has its own
  wire wp_any = vme_err_r.pending || sbus_err_r.pending;
  assign irq_lines = route_irq(wperr_irq_cfg, wp_any) | route_irq(late_irq_cfg, late_err_r.pending);

  // Freeze is one-way until reset, so a stray write cannot unroute a fail interrupt
  always_ff @(posedge clk) begin
    if (rst) begin
      fail_cfg_r <= '0;
      frozen_r <= 1'b0;
      dtb_r <= 1'b0;
    end else if (ce) begin
      if (fail_cfg_wr && !frozen_r) fail_cfg_r <= fail_cfg_in;
      if (freeze_set) frozen_r <= 1'b1;
      dtb_r <= dtb_drv_en;
    end
  end

  assign fail_cfg = fail_cfg_r;
  assign frozen = frozen_r;
  assign dtb_drivers_on = dtb_r;

endmodule : vmb_bridge

`default_nettype wire

// ### tb/vmb_bridge_props.sv
// Port-level assertions and covers for the broadcast bridge
`timescale 1ns/1ps
`default_nettype none

module vmb_bridge_props
  import vmb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] chan_en,
  input wire logic [7:0] page,
  input wire logic bc_valid,
  input wire logic [31:0] bc_addr,
  input wire logic bc_accepted,
  input wire logic bc_rejected,
  input wire logic [1:0] accepted_pending,
  input wire logic [1:0] rejected_message_pending,
  input wire logic rd_req,
  input wire logic rd_done,
  input wire logic send_req,
  input wire logic send_chan,
  input wire logic [31:0] send_slots,
  input wire logic send_busy,
  input wire logic m_req,
  input wire logic [31:0] m_addr,
  input wire logic [5:0] m_am,
  input wire logic m_posted,
  input wire logic vme_posted_write_error_pending,
  input wire vmb_irq_sel_t wperr_irq_cfg,
  input wire logic [7:0] irq_lines,
  input wire logic freeze_set,
  input wire logic frozen,
  input wire vmb_fail_cfg_t fail_cfg,
  input wire logic dtb_drv_en,
  input wire logic dtb_drivers_on
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  a_rej_flag_set: assert property ((bc_rejected && !bc_addr[23]) |=> rejected_message_pending[0])
    else $error("channel 0 rejected flag not set");
  a_acc_flag_set: assert property ((bc_accepted && bc_addr[23]) |=> accepted_pending[1])
    else $error("channel 1 accepted flag not set");
  a_page_match: assert property ((bc_accepted || bc_rejected) |-> bc_valid && bc_addr[31:24] == page)
    else $error("broadcast answered outside the page");
  a_chan_off_rej: assert property ((bc_valid && !chan_en[bc_addr[23]]) |-> !bc_accepted)
    else $error("disabled channel accepted a message");
  a_rd_two_cyc: assert property (rd_done |-> $past(rd_req, 2))
    else $error("read answer not two cycles after request");
  a_win_a32: assert property (m_req |-> m_am == 6'h09 && !m_posted)
    else $error("send window not A32 unposted");
  a_win_addr: assert property (m_req |-> m_addr == {page, send_chan, 2'h0, send_slots[20:0]})
    else $error("send address layout wrong");
  a_send_start: assert property ((send_req && !send_busy) |=> send_busy && m_req)
    else $error("send did not start the bus write");
  a_freeze_set: assert property (freeze_set |=> frozen)
    else $error("freeze did not take");
  a_freeze_hold: assert property (frozen |=> $stable(fail_cfg))
    else $error("fail settings changed while frozen");
  a_wperr_route: assert property ((vme_posted_write_error_pending && wperr_irq_cfg.en) |-> irq_lines[wperr_irq_cfg.map])
    else $error("posting error interrupt not on its line");
  a_dtb_follow: assert property ((dtb_drv_en ##1 dtb_drv_en) |-> dtb_drivers_on)
    else $error("drivers not enabled");

  c_reject: cover property (bc_rejected);
  c_send: cover property (send_req && !send_busy);
  c_read: cover property (rd_done);
endmodule : vmb_bridge_props

bind vmb_bridge vmb_bridge_props i_props (.*);
`default_nettype wire

// ### tb/vmb_far_host.sv
// Far-side model of the master window: other hosts answering a broadcast write
`timescale 1ns/1ps
`default_nettype none

module vmb_far_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic m_req,
  input wire logic stall,
  input wire logic rej,
  input wire logic [3:0] dly,
  output logic m_ack,
  output logic m_rejected
);
  logic [3:0] cnt_r;
  logic done_r;
  logic tog_r;

  // One ack per write, dly+1 cycles after the request rises; stall models a hung bus for the timer
  always_ff @(posedge clk) begin
    tog_r <= ~tog_r & ~rst;
    if (rst || !m_req) begin
      cnt_r <= 4'h0;
      done_r <= 1'b0;
      m_ack <= 1'b0;
    end else begin
      m_ack <= !done_r && !stall && cnt_r == dly;
      done_r <= done_r || (!stall && cnt_r == dly);
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Reject only means something with the ack, so it wanders otherwise
  assign m_rejected = m_ack ? rej : tog_r;
endmodule : vmb_far_host
`default_nettype wire

// ### tb/vmb_bridge_tb_top.sv
// Self-checking bench for the broadcast bridge
`timescale 1ns/1ps
`default_nettype none

module vmb_bridge_tb_top;
  import vmb_pkg::*;
  logic clk = 0, rst = 1, ce = 1, user_access_ok = 0, bc_valid = 0, rd_req = 0, rd_chan = 0;
  logic rd_priv = 1, send_req = 0, send_chan = 0, timer_en = 0, stall = 0, rej = 0;
  logic vme_wperr_evt = 0, sbus_wperr_evt = 0, late_err_evt = 0, late_err_clear = 0;
  logic wperr_clear_vme = 0, wperr_clear_sbus = 0, fail_cfg_wr = 0, freeze_set = 0, dtb_drv_en = 0;
  logic [1:0] chan_en = 2'h3, timeout_code = 2'h1;
  logic [1:0] clear_accepted_pending = 2'h0, clear_rejected_pending = 2'h0;
  logic [3:0] dly = 4'h0;
  logic [4:0] slot_num = 5'h0f; // Unique in the system
  logic [7:0] page = 8'hfa;
  logic [31:0] bc_addr = 32'h0, bc_data = 32'h0, send_msg = 32'h0, send_slots = 32'h0;
  logic [31:0] vme_wperr_addr = 32'h0, sbus_wperr_addr = 32'h0, late_err_addr_in = 32'h0;
  vmb_irq_sel_t wperr_irq_cfg = '0, late_irq_cfg = '0;
  vmb_fail_cfg_t fail_cfg_in = '0, fail_cfg;
  logic bc_accepted, bc_rejected, rd_done, rd_avail, rd_denied, send_busy, send_done, send_ok;
  logic send_berr, m_req, m_posted, m_ack, m_rejected, m_abort, vme_posted_write_error_pending;
  logic sbus_posted_write_error_pending, late_error_pending, frozen, dtb_drivers_on;
  logic [1:0] msg_available, accepted_pending, rejected_message_pending;
  logic [5:0] m_am;
  logic [7:0] irq_lines;
  logic [31:0] rd_data, m_addr, m_data, vme_wperr_addr_q, sbus_wperr_addr_q, late_err_addr_q;
  int err_count = 0, n_compared = 0, cyc = 0;

  // Short timeouts keep the stalled-bus runs brief
  vmb_bridge #(.TO1_CYC(20), .TO2_CYC(40), .TO3_CYC(80), .DEPTH(4)) i_dut (.*);
  vmb_far_host i_far (.clk(clk), .rst(rst), .m_req(m_req), .stall(stall), .rej(rej),
    .dly(dly), .m_ack(m_ack), .m_rejected(m_rejected));

  always #5 clk = ~clk;

  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 6000) begin
      err_count++;
      print_verdict;
    end
  end

  task print_verdict;
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task tick;
    @(posedge clk);
    #1;
  endtask : tick

  // Valid stays high between calls so bursts run back to back
  task bc(input logic [31:0] a, input logic [31:0] d, input logic ea, input logic er);
    bc_valid = 1;
    bc_addr = a;
    bc_data = d;
    #1;
    chk(bc_accepted, ea);
    chk(bc_rejected, er);
    tick;
  endtask : bc

  // Request is taken at the first edge, answer lands two cycles on
  task rd(input logic ch, input logic pv, input logic av, input logic dn, input logic [31:0] d);
    rd_req = 1;
    rd_chan = ch;
    rd_priv = pv;
    tick;
    rd_req = 0;
    tick;
    chk(rd_done, 1);
    chk(rd_avail, av);
    chk(rd_denied, dn);
    if (!dn) chk(rd_data, d);
    tick;
  endtask : rd

  // Slots and channel are held until done; n counts bus-busy cycles
  task snd(input logic [31:0] sl, input logic ok, input logic be, output int n);
    int na;
    send_req = 1;
    send_chan = 1;
    send_slots = sl;
    send_msg = 32'h1234aa55;
    tick;
    send_req = 0;
    n = 0;
    na = 0;
    for (int i = 0; i < 300 && send_done !== 1'b1; i++) begin
      if (n == 0) chk(m_addr, {page, 1'b1, 2'b00, sl[20:0]});
      if (n == 0) chk(m_data, 32'h1234aa55);
      n += int'(m_req === 1'b1);
      na += int'(m_abort === 1'b1);
      tick;
    end
    chk(send_done, 1);
    chk(send_ok, ok);
    chk(send_berr, be);
    chk(na, be);
    tick;
  endtask : snd

  task t_recv;
    bc(32'hfb004000, 32'h1, 0, 0);
    bc(32'hfa002000, 32'h2, 0, 0);
    for (int i = 0; i < 4; i++) bc(32'hfa004000, 32'hc0de0000 + i, 1, 0);
    bc(32'hfa004000, 32'hbad, 0, 1);
    chan_en = 2'h1;
    bc(32'hfa804000, 32'hbad, 0, 1);
    bc_valid = 0;
    chk({msg_available, accepted_pending, rejected_message_pending}, 6'h17);
    clear_rejected_pending = 2'h1;
    tick;
    clear_rejected_pending = 2'h0;
    chk(rejected_message_pending, 2'h2);
    clear_rejected_pending = 2'h2;
    chan_en = 2'h3;
    tick;
    clear_rejected_pending = 2'h0;
    chk(rejected_message_pending, 2'h0);
  endtask : t_recv

  task t_read;
    rd(0, 0, 0, 1, 0);
    for (int i = 0; i < 4; i++) rd(0, 1, 1, 0, 32'hc0de0000 + i);
    rd(0, 1, 0, 0, 0);
    user_access_ok = 1;
    rd(1, 0, 0, 0, 0);
  endtask : t_read

  task t_send;
    int n;
    snd(32'h8000400f, 1, 0, n); // Bit 31 ignored, bit 14 is us
    rd(1, 1, 1, 0, 32'h1234aa55);
    rd(1, 1, 0, 0, 0);
    rej = 1;
    dly = 4'h6;
    snd(32'h1, 0, 0, n);
    rej = 0;
  endtask : t_send

  // Codes 0..3 against a hung bus; code 0 must give the longest period
  task t_timeout;
    int n;
    int lim;
    stall = 1;
    timer_en = 1;
    for (int k = 0; k < 4; k++) begin
      timeout_code = k[1:0];
      lim = (k == 1) ? 20 : (k == 2) ? 40 : 80;
      snd(32'h1, 0, 1, n);
      chk(n, lim);
    end
    stall = 0;
  endtask : t_timeout

  task t_err;
    wperr_irq_cfg = {3'h5, 1'b0};
    vme_wperr_evt = 1;
    vme_wperr_addr = 32'hdead0010;
    tick;
    vme_wperr_evt = 0;
    chk({vme_posted_write_error_pending, sbus_posted_write_error_pending}, 2'h2);
    chk(vme_wperr_addr_q, 32'hdead0010);
    chk(irq_lines, 8'h0);
    wperr_irq_cfg.en = 1;
    late_irq_cfg = {3'h2, 1'b1};
    sbus_wperr_evt = 1;
    sbus_wperr_addr = 32'hbeef0020;
    late_err_evt = 1;
    late_err_addr_in = 32'h0f0f0030;
    tick;
    sbus_wperr_evt = 0;
    late_err_evt = 0;
    chk(sbus_wperr_addr_q, 32'hbeef0020);
    chk(late_err_addr_q, 32'h0f0f0030);
    chk({vme_posted_write_error_pending, sbus_posted_write_error_pending,
      late_error_pending, irq_lines}, 11'h724);
    wperr_clear_vme = 1;
    wperr_clear_sbus = 1;
    late_err_clear = 1;
    tick;
    wperr_clear_vme = 0;
    wperr_clear_sbus = 0;
    late_err_clear = 0;
    chk({late_error_pending, irq_lines}, 9'h0);
    // With the clock enable low an error event must not be captured
    ce = 0;
    vme_wperr_evt = 1;
    tick;
    vme_wperr_evt = 0;
    ce = 1;
    chk(vme_posted_write_error_pending, 0);
  endtask : t_err

  task t_freeze;
    fail_cfg_in = 12'h9a5;
    fail_cfg_wr = 1;
    tick;
    fail_cfg_wr = 0;
    freeze_set = 1;
    tick;
    freeze_set = 0;
    chk({frozen, fail_cfg}, 13'h19a5);
    fail_cfg_in = 12'h123;
    fail_cfg_wr = 1;
    tick;
    fail_cfg_wr = 0;
    chk(fail_cfg, 12'h9a5);
    dtb_drv_en = 1;
    tick;
    tick;
    chk(dtb_drivers_on, 1);
    dtb_drv_en = 0;
    tick;
    tick;
    chk(dtb_drivers_on, 0);
  endtask : t_freeze

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 0;
    t_recv;
    t_read;
    t_send;
    t_timeout;
    t_err;
    t_freeze;
    print_verdict;
  end
endmodule : vmb_bridge_tb_top
`default_nettype wire
